// ==== hw/csm_regs_map.svh ====
// register map, field positions, codes and timing figures of the charger status/mode bank
// assumes a 125 MHz register clock and byte addresses of four times the register index
`ifndef CSM_REGS_MAP_SVH
`define CSM_REGS_MAP_SVH

// register indices, byte address is index times four
`define CSM_IDX_STATUS 8'h15
`define CSM_IDX_MODE 8'h16
`define CSM_IDX_IRQ_STAT 8'h18
`define CSM_IDX_IRQ_MASK 8'h19
`define CSM_IDX_SHIFT 2

// reset values
`define CSM_MODE_RESET 8'h04
`define CSM_IRQ_RESET 8'h00
`define CSM_BYTE_ZERO 8'h00
`define CSM_STATUS_RESET 8'h20

// field positions
`define CSM_THERM_BIT 7
`define CSM_ZONE_MSB 6
`define CSM_ZONE_LSB 4
`define CSM_BYPASS_MSB 3
`define CSM_MODE_MSB 3
`define CSM_SPARE_MSB 7
`define CSM_SPARE_LSB 4
`define CSM_IRQ_BITS 6

// thermistor zone codes
`define CSM_ZONE_COLD 3'h0
`define CSM_ZONE_COOL 3'h1
`define CSM_ZONE_NORMAL 3'h2
`define CSM_ZONE_WARM 3'h3
`define CSM_ZONE_HOT 3'h4
`define CSM_ZONE_REMOVED 3'h5
`define CSM_ZONE_OFF 3'h6

// power-selection mode codes
`define CSM_MODE_BATT 4'h0
`define CSM_MODE_LIN 4'h1
`define CSM_MODE_BATT2 4'h2
`define CSM_MODE_BATT3 4'h3
`define CSM_MODE_BUCK 4'h4
`define CSM_MODE_CHG 4'h5
`define CSM_MODE_CHG2 4'h6
`define CSM_MODE_BUCK_LIN 4'h7
`define CSM_MODE_BOOST 4'h9
`define CSM_MODE_OTG 4'hA
`define CSM_MODE_OTG_E 4'hE
`define CSM_MODE_OTG_F 4'hF

// timing figures
`define CSM_CLK_NS 8.0
`define CSM_REV_HOLD_MS 37.5
`define CSM_BST_PERSIST_MS 30.0
`define CSM_NS_PER_MS 1.0E6

`endif

// ==== hw/csm_pkg.sv ====
// types shared by the charger status/mode bank, its checker and its bench
// assumes the map header supplies every number
package csm_pkg;

    // analogue comparator levels arriving from the charger core
    typedef struct packed {
        logic junction_hot;       // above junction_limit_setting
        logic zone_cold;
        logic zone_cool;
        logic zone_warm;
        logic zone_hot;
        logic battery_removed;    // thermistor_pin open
        logic monitor_off;        // thermistor monitoring disabled
        logic reverse_switch_limit_hit;
        logic boost_limit_hit;
        logic buck_negative_limit_hit;
        logic boost_startup_done;
    } csm_sense_s;

    // converter and switch controls decoded from the mode field
    typedef struct packed {
        logic charger_en;
        logic reverse_out_en;
        logic buck_en;
        logic boost_en;
        logic battery_switch_on;
        logic battery_linear_chg;
        logic input_switch_on;
    } csm_conv_s;

    typedef logic [7:0] csm_byte_t;

endpackage

// ==== hw/csm_dwell_timer.sv ====
// dwell counter: measures how long run_i has stayed high, saturating at LIMIT
// assumes run_i is already synchronous to clk_i
`timescale 1ns/1ps

module csm_dwell_timer #(
    parameter int unsigned LIMIT = 4,
    parameter bit START_FULL = 1'b0
) (
    input wire logic clk_i,    // register clock
    input wire logic reset_i,  // synchronous reset, high
    input wire logic run_i,    // count while high, clear while low
    output logic done_o        // high once LIMIT cycles elapsed
);
    localparam int unsigned CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] FULL = CW'(LIMIT);
    localparam logic [CW-1:0] INIT = START_FULL ? FULL : '0;

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;

    // saturate so a long run never wraps back into a false short count
    assign nxt_cnt = !run_i ? '0 : (cnt_ff == FULL) ? FULL : cnt_ff + CW'(1);
    assign done_o = (cnt_ff == FULL);

    // count register
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt_ff <= INIT;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule // csm_dwell_timer

// ==== hw/csm_regs.sv ====
// charger status and power-selection mode register bank with APB slave and interrupt
// assumes analogue status levels arrive asynchronously and are synchronised here,
// and that the bus master holds each request until it sees pready high; the
// status byte is live, so only the two latched bypass bits keep history
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "csm_regs_map.svh"

module csm_regs #(
    parameter int unsigned ADDR_W = 12,
    parameter int unsigned REV_HOLD_CYC =
        $rtoi(`CSM_REV_HOLD_MS * `CSM_NS_PER_MS / `CSM_CLK_NS),
    parameter int unsigned BST_PERSIST_CYC =
        $rtoi($ceil(`CSM_BST_PERSIST_MS * `CSM_NS_PER_MS / `CSM_CLK_NS))
) (
    input wire logic clk_i,                  // register clock, 125 MHz
    input wire logic reset_i,                // synchronous reset, high
    input wire logic psel_i,                 // apb select
    input wire logic penable_i,              // apb access phase
    input wire logic pwrite_i,               // apb direction
    input wire logic [ADDR_W-1:0] paddr_i,   // apb byte address
    input wire logic [31:0] pwdata_i,        // apb write data
    input wire logic [3:0] pstrb_i,          // apb byte strobes
    output logic pready_o,                   // apb ready, zero wait
    output logic [31:0] prdata_o,            // apb read data
    output logic pslverr_o,                  // apb error on unmapped address
    input wire csm_pkg::csm_sense_s sense_i, // asynchronous analogue levels
    output csm_pkg::csm_conv_s conv_o,       // converter controls
    output logic irq_o                       // level interrupt
);
    import csm_pkg::*;

    // register byte addresses; any other word answers with an error
    localparam logic [ADDR_W-1:0] A_STATUS = ADDR_W'(`CSM_IDX_STATUS) << `CSM_IDX_SHIFT;
    localparam logic [ADDR_W-1:0] A_MODE = ADDR_W'(`CSM_IDX_MODE) << `CSM_IDX_SHIFT;
    localparam logic [ADDR_W-1:0] A_ISTAT = ADDR_W'(`CSM_IDX_IRQ_STAT) << `CSM_IDX_SHIFT;
    localparam logic [ADDR_W-1:0] A_IMASK = ADDR_W'(`CSM_IDX_IRQ_MASK) << `CSM_IDX_SHIFT;

    // mode field to converter controls; reserved codes park with only the
    // battery switch on, the least disruptive state for the system; each
    // branch except the buck-plus-linear one and the default names the converters it keeps off so the intent stays visible
    function automatic csm_conv_s conv_decode(input logic [3:0] m);
        csm_conv_s c;
        c = '0;
        c.battery_switch_on = 1'b1;
        case (m)
            `CSM_MODE_BATT, `CSM_MODE_BATT2, `CSM_MODE_BATT3: begin
                c.charger_en = 1'b0;
                c.reverse_out_en = 1'b0;
                c.buck_en = 1'b0;
                c.boost_en = 1'b0;
                c.battery_switch_on = 1'b1;
            end
            `CSM_MODE_LIN: begin
                c.charger_en = 1'b0;
                c.reverse_out_en = 1'b0;
                c.buck_en = 1'b0;
                c.boost_en = 1'b0;
                c.battery_linear_chg = 1'b1;
            end
            `CSM_MODE_BUCK: begin
                c.charger_en = 1'b0;
                c.reverse_out_en = 1'b0;
                c.boost_en = 1'b0;
                c.buck_en = 1'b1;
            end
            `CSM_MODE_CHG, `CSM_MODE_CHG2: begin
                c.reverse_out_en = 1'b0;
                c.boost_en = 1'b0;
                c.charger_en = 1'b1;
                c.buck_en = 1'b1;
            end
            `CSM_MODE_BUCK_LIN: begin
                c.charger_en = 1'b0;
                c.buck_en = 1'b1;
                c.battery_linear_chg = 1'b1;
            end
            `CSM_MODE_BOOST: begin
                c.charger_en = 1'b0;
                c.buck_en = 1'b0;
                c.reverse_out_en = 1'b0;
                c.boost_en = 1'b1;
                c.input_switch_on = 1'b0;
            end
            `CSM_MODE_OTG: begin
                c.charger_en = 1'b0;
                c.buck_en = 1'b0;
                c.boost_en = 1'b1;
                c.reverse_out_en = 1'b1;
                c.input_switch_on = 1'b1;
            end
            default: begin
                c.battery_switch_on = 1'b1;
            end
        endcase
        return c;
    endfunction

    // zone comparators to zone code; removal and disabled monitoring win
    // because the temperature comparators are meaningless in those cases
    function automatic logic [2:0] zone_encode(input csm_sense_s s);
        logic [2:0] z;
        z = `CSM_ZONE_NORMAL;
        if (s.monitor_off) begin
            z = `CSM_ZONE_OFF;
        end else if (s.battery_removed) begin
            z = `CSM_ZONE_REMOVED;
        end else if (s.zone_cold) begin
            z = `CSM_ZONE_COLD;
        end else if (s.zone_hot) begin
            z = `CSM_ZONE_HOT;
            // cool and warm trail the suspend zones, so the more severe report wins
        end else if (s.zone_cool) begin
            z = `CSM_ZONE_COOL;
        end else if (s.zone_warm) begin
            z = `CSM_ZONE_WARM;
        end
        return z;
    endfunction

    // state
    csm_sense_s sync1_ff;
    csm_sense_s sync2_ff;
    csm_byte_t mode_ff;
    csm_byte_t prdata_ff;
    csm_byte_t prev_status_ff;
    // latched bypass bits, released only by a status read
    logic rev_latch_ff;
    logic bck_latch_ff;
    logic [`CSM_IRQ_BITS-1:0] irq_stat_ff;
    logic [`CSM_IRQ_BITS-1:0] irq_mask_ff;
    logic irq_ff;
    csm_conv_s conv_ff;
    logic pslverr_ff;

    // next values
    csm_byte_t nxt_mode;
    csm_byte_t nxt_prdata;
    logic nxt_rev_latch;
    logic nxt_bck_latch;
    logic [`CSM_IRQ_BITS-1:0] nxt_irq_stat;
    logic [`CSM_IRQ_BITS-1:0] nxt_irq_mask;

    // bus decode
    wire setup_ph = psel_i & ~penable_i;
    wire access_ph = psel_i & penable_i;
    wire hit_status = (paddr_i == A_STATUS);
    wire hit_mode = (paddr_i == A_MODE);
    wire hit_istat = (paddr_i == A_ISTAT);
    wire hit_imask = (paddr_i == A_IMASK);
    wire mapped = hit_status | hit_mode | hit_istat | hit_imask;

    // writes land at the access edge, byte lane zero only; the status byte has
    // no write strobe, so a write there is dropped without an error
    wire wr_low = access_ph & pwrite_i & pstrb_i[0];
    wire wr_mode = wr_low & hit_mode;
    wire wr_istat = wr_low & hit_istat;
    wire wr_imask = wr_low & hit_imask;

    // a status read releases latched bits at the same access edge
    wire rd_status = access_ph & ~pwrite_i & hit_status;

    // flag sources from the synchronised analogue levels
    wire [3:0] mode_sel = mode_ff[`CSM_MODE_MSB:0];
    wire otg_mode = (mode_sel == `CSM_MODE_OTG) | (mode_sel == `CSM_MODE_OTG_E) |
                    (mode_sel == `CSM_MODE_OTG_F);
    wire rev_hit = sync2_ff.reverse_switch_limit_hit & otg_mode;
    wire bck_hit = sync2_ff.buck_negative_limit_hit;
    wire rev_hold_done;
    wire bst_persisted;

    // a hit restarts the hold window; the window lapses after the hold time
    csm_dwell_timer #(
        .LIMIT(REV_HOLD_CYC),
        .START_FULL(1'b1)
    ) u_rev_hold (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .run_i(~rev_hit),
        .done_o(rev_hold_done)
    );

    // boost limit must persist without a break before it is reported
    csm_dwell_timer #(
        .LIMIT(BST_PERSIST_CYC),
        .START_FULL(1'b0)
    ) u_bst_persist (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .run_i(sync2_ff.boost_limit_hit),
        .done_o(bst_persisted)
    );

    // bypass flag bits, each driven on its own so they combine freely
    wire bypass_b0 = rev_latch_ff | ~rev_hold_done;
    wire bypass_b1 = bst_persisted;
    wire bypass_b2 = bck_latch_ff;
    wire bypass_b3 = sync2_ff.boost_startup_done & (mode_sel == `CSM_MODE_BOOST);
    wire [3:0] bypass_flags = {bypass_b3, bypass_b2, bypass_b1, bypass_b0};

    // live status byte
    wire [2:0] zone_code = zone_encode(sync2_ff);
    wire csm_byte_t status_now = {sync2_ff.junction_hot, zone_code, bypass_flags};

    // latched bits: only bits that the host actually saw are released by the
    // read, so an event landing between capture and access is not lost
    wire clr_rev = rd_status & prdata_ff[0];
    wire clr_bck = rd_status & prdata_ff[2];
    assign nxt_rev_latch = rev_hit | (rev_latch_ff & ~clr_rev);
    assign nxt_bck_latch = bck_hit | (bck_latch_ff & ~clr_bck);

    // interrupt events: thermal flag rise, zone change, each bypass bit rise
    wire zone_changed = (status_now[`CSM_ZONE_MSB:`CSM_ZONE_LSB] !=
                         prev_status_ff[`CSM_ZONE_MSB:`CSM_ZONE_LSB]);
    wire therm_rise = status_now[`CSM_THERM_BIT] & ~prev_status_ff[`CSM_THERM_BIT];
    wire [3:0] bypass_rise = bypass_flags & ~prev_status_ff[`CSM_BYPASS_MSB:0];
    wire [`CSM_IRQ_BITS-1:0] irq_evt = {bypass_rise, zone_changed, therm_rise};

    // write one to clear, a coincident event keeps its bit
    assign nxt_irq_stat = irq_evt |
        (irq_stat_ff & ~(wr_istat ? pwdata_i[`CSM_IRQ_BITS-1:0] : '0));
    assign nxt_irq_mask = wr_imask ? pwdata_i[`CSM_IRQ_BITS-1:0] : irq_mask_ff;

    // mode register keeps the spare bits as plain storage
    assign nxt_mode = wr_mode ? pwdata_i[7:0] : mode_ff;

    // interrupt registers widened to the byte; the unused top bits read zero
    wire csm_byte_t rd_istat = csm_byte_t'(irq_stat_ff);
    wire csm_byte_t rd_imask = csm_byte_t'(irq_mask_ff);
    wire csm_byte_t rd_byte = hit_status ? status_now :
                              hit_mode ? mode_ff :
                              hit_istat ? rd_istat :
                              hit_imask ? rd_imask : `CSM_BYTE_ZERO;

    // read mux, captured in the setup phase so the answer is a flop; a flag
    // that rises during the access is left for the next read, not cleared
    // unseen
    assign nxt_prdata = setup_ph ? rd_byte : prdata_ff;

    // bus answers: always ready, error only for unmapped addresses
    assign pready_o = 1'b1;
    assign pslverr_o = pslverr_ff & access_ph;
    assign prdata_o = {24'h000000, prdata_ff};
    assign conv_o = conv_ff;
    assign irq_o = irq_ff;

    // two-stage synchroniser for the analogue levels; each bit is caught on
    // its own, so two comparators that move together may show a cycle apart
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= sense_i;
            sync2_ff <= sync1_ff;
        end
    end

    // software registers and latched flags
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_ff <= `CSM_MODE_RESET;
            rev_latch_ff <= 1'b0;
            bck_latch_ff <= 1'b0;
            irq_mask_ff <= '0;
        end else begin
            mode_ff <= nxt_mode;
            rev_latch_ff <= nxt_rev_latch;
            bck_latch_ff <= nxt_bck_latch;
            irq_mask_ff <= nxt_irq_mask;
        end
    end

    // bus read path
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prdata_ff <= `CSM_BYTE_ZERO;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff <= nxt_prdata;
            pslverr_ff <= setup_ph ? ~mapped : pslverr_ff;
        end
    end

    // interrupt status and edge memory; the memory starts at the idle status
    // byte, so leaving reset does not look like a zone change
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_stat_ff <= '0;
            prev_status_ff <= `CSM_STATUS_RESET;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            prev_status_ff <= status_now;
        end
    end

    // registered outputs; the controls follow a mode write one edge later
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_ff <= 1'b0;
            conv_ff <= conv_decode(`CSM_MODE_BUCK);
        end else begin
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
            conv_ff <= conv_decode(mode_sel);
        end
    end
endmodule // csm_regs

// ==== test/csm_regs_assertions.sv ====
// concurrent checks on the ports of the charger status and mode bank
// assumes it is bound to csm_regs and that sense levels are held steady around reads
`timescale 1ns/1ps

module csm_regs_chk #(
    parameter int unsigned ADDR_W = 12
) (
    input wire logic clk_i,                  // register clock
    input wire logic reset_i,                // synchronous reset, high
    input wire logic psel_i,                 // apb select
    input wire logic penable_i,              // apb access phase
    input wire logic pwrite_i,               // apb direction
    input wire logic [ADDR_W-1:0] paddr_i,   // apb byte address
    input wire logic [31:0] pwdata_i,        // apb write data
    input wire logic [3:0] pstrb_i,          // apb byte strobes
    input wire logic pready_o,               // apb ready
    input wire logic [31:0] prdata_o,        // apb read data
    input wire logic pslverr_o,              // apb error
    input wire csm_pkg::csm_sense_s sense_i, // analogue levels
    input wire csm_pkg::csm_conv_s conv_o,   // converter controls
    input wire logic irq_o                   // level interrupt
);
    import csm_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    logic [6:0] conv_exp;
    wire logic acc = psel_i && penable_i && pready_o;
    wire logic mode_wr = acc && pwrite_i && pstrb_i[0] && paddr_i == ADDR_W'(8'h58);
    wire logic mode_doc = conv_exp != 7'h7F;

    // expected controls per documented mode code; undocumented codes are left unjudged
    always_comb begin
        case (pwdata_i[3:0])
            4'h0: conv_exp = 7'h04;
            4'h1: conv_exp = 7'h06;
            4'h4: conv_exp = 7'h14;
            4'h5: conv_exp = 7'h54;
            4'h9: conv_exp = 7'h0C;
            4'hA: conv_exp = 7'h2D;
            default: conv_exp = 7'h7F;
        endcase
    end

    // status read access; the sense level must have sat still so sync latency cannot matter
    sequence s_status_read;
        acc && !pwrite_i && paddr_i == ADDR_W'(8'h54);
    endsequence
    sequence s_steady(x);
        $past(x, 2) == $past(x, 4) && $past(x, 3) == $past(x, 4);
    endsequence

    property p_reset_mode;
        $fell(reset_i) |-> conv_o == 7'h14;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("controls not buck only after reset");
    property p_mode_decode;
        mode_wr && mode_doc |-> ##2 conv_o == $past(conv_exp, 2);
    endproperty
    a_mode_decode: assert property (p_mode_decode) else $error("controls do not follow mode");
    property p_conv_hold;
        !$past(reset_i) && $changed(conv_o) |-> $past(mode_wr, 2);
    endproperty
    a_conv_hold: assert property (p_conv_hold) else $error("controls moved without a mode write");
    property p_thermal;
        s_status_read ##0 s_steady(sense_i.junction_hot)
            |-> prdata_o[7] == $past(sense_i.junction_hot, 3);
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal flag wrong");
    property p_zone_off;
        s_status_read ##0 s_steady(sense_i.monitor_off) ##0 $past(sense_i.monitor_off, 3)
            |-> prdata_o[6:4] == 3'h6;
    endproperty
    a_zone_off: assert property (p_zone_off) else $error("zone not monitoring off");
    property p_zone_removed;
        s_status_read ##0 s_steady(sense_i.battery_removed) ##0 s_steady(sense_i.monitor_off)
            ##0 ($past(sense_i.battery_removed, 3) && !$past(sense_i.monitor_off, 3))
            |-> prdata_o[6:4] == 3'h5;
    endproperty
    a_zone_removed: assert property (p_zone_removed) else $error("zone not removed");
    property p_startup_gate;
        s_status_read ##0 s_steady(sense_i.boost_startup_done)
            ##0 !$past(sense_i.boost_startup_done, 3) |-> !prdata_o[3];
    endproperty
    a_startup_gate: assert property (p_startup_gate) else $error("start-up flag without cause");
    property p_boost_level;
        s_status_read ##0 s_steady(sense_i.boost_limit_hit)
            ##0 !$past(sense_i.boost_limit_hit, 3) |-> !prdata_o[1];
    endproperty
    a_boost_level: assert property (p_boost_level) else $error("boost flag without cause");
endmodule // csm_regs_chk

bind csm_regs csm_regs_chk #(.ADDR_W(ADDR_W)) u_chk (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .sense_i(sense_i),
    .conv_o(conv_o), .irq_o(irq_o)
);

// ==== test/charger_status_and_mode_regs_test.sv ====
// self-checking bench for the charger status and mode bank
// assumes a 125 MHz clock, shortened dwell counts and the bound checker
`timescale 1ns/1ps

module charger_status_and_mode_regs_test;
    import csm_pkg::*;
    localparam int unsigned REV_HOLD = 20;
    localparam int unsigned BST_PERSIST = 10;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [3:0] pstrb_i = 4'hF;
    logic [3:0] strb = 4'hF;
    logic pready_o, pslverr_o, irq_o, err;
    logic [31:0] prdata_o, rd;
    csm_sense_s sense_i = '0;
    csm_conv_s conv_o;
    int n_errors = 0;
    int check_count = 0;

    always #4 clk_i = ~clk_i;

    csm_regs #(.ADDR_W(12), .REV_HOLD_CYC(REV_HOLD), .BST_PERSIST_CYC(BST_PERSIST)) DUT (
        .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .sense_i(sense_i),
        .conv_o(conv_o), .irq_o(irq_o)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen high, answer taken at that edge;
    // only the watchdog ends the wait
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= addr;
        pwdata_i <= data;
        pstrb_i <= strb;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(rd, exp);
    endtask

    // four edges let the level clear the two-flop synchroniser
    task automatic set_sense(input logic [10:0] v);
        @(posedge clk_i);
        sense_i <= v;
        repeat (4) @(posedge clk_i);
    endtask

    task automatic t_reset;
        check({25'h0, conv_o}, 32'h14);
        rdchk(12'h058, 32'h04);
        rdchk(12'h054, 32'h20);
        check({31'h0, irq_o}, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_modes;
        logic [3:0] m [6] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h9, 4'hA};
        logic [6:0] c [6] = '{7'h04, 7'h06, 7'h14, 7'h54, 7'h0C, 7'h2D};
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 12'h058, {24'h0, 4'h5, m[i]});
            repeat (3) @(posedge clk_i);
            check({25'h0, conv_o}, {25'h0, c[i]});
            rdchk(12'h058, {24'h0, 4'h5, m[i]});
        end
        strb = 4'h0;
        apb(1'b1, 12'h058, 32'h04);
        strb = 4'hF;
        rdchk(12'h058, 32'h5A);
        apb(1'b1, 12'h05C, 32'hFF);
        check({31'h0, err}, 32'h1);
        rdchk(12'h05C, 32'h0);
        apb(1'b1, 12'h058, 32'h04);
        $display("test modes done");
    endtask

    task automatic t_status;
        logic [10:0] v [6] = '{11'h200, 11'h100, 11'h080, 11'h040, 11'h020, 11'h010};
        logic [2:0] z [6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6};
        apb(1'b1, 12'h054, 32'hFF);
        check({31'h0, err}, 32'h0);
        set_sense(11'h400);
        rdchk(12'h054, 32'hA0);
        set_sense(11'h000);
        rdchk(12'h054, 32'h20);
        for (int i = 0; i < 6; i++) begin
            set_sense(v[i]);
            rdchk(12'h054, {25'h0, z[i], 4'h0});
        end
        set_sense(11'h000);
        $display("test status done");
    endtask

    // reverse limit is ignored in buck mode; latched bits survive the hold window
    task automatic t_bypass;
        set_sense(11'h008);
        set_sense(11'h000);
        repeat (REV_HOLD + 5) @(posedge clk_i);
        rdchk(12'h054, 32'h20);
        apb(1'b1, 12'h058, 32'h0A);
        set_sense(11'h00A);
        set_sense(11'h000);
        repeat (REV_HOLD + 5) @(posedge clk_i);
        rdchk(12'h054, 32'h25);
        rdchk(12'h054, 32'h20);
        $display("test bypass done");
    endtask

    task automatic t_boost;
        apb(1'b1, 12'h058, 32'h09);
        set_sense(11'h004);
        rdchk(12'h054, 32'h20);
        repeat (BST_PERSIST + 4) @(posedge clk_i);
        rdchk(12'h054, 32'h22);
        set_sense(11'h001);
        rdchk(12'h054, 32'h28);
        apb(1'b1, 12'h058, 32'h04);
        repeat (3) @(posedge clk_i);
        rdchk(12'h054, 32'h20);
        set_sense(11'h000);
        $display("test boost done");
    endtask

    // thermal rise raises the line only while unmasked and until cleared
    task automatic t_irq;
        apb(1'b1, 12'h060, 32'hFF);
        rdchk(12'h060, 32'h00);
        apb(1'b1, 12'h064, 32'h01);
        set_sense(11'h400);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        rdchk(12'h060, 32'h01);
        apb(1'b1, 12'h064, 32'h00);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        apb(1'b1, 12'h064, 32'h01);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        apb(1'b1, 12'h060, 32'h01);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        $display("test irq done");
    endtask

    task automatic final_report;
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset;
        t_modes;
        t_status;
        t_bypass;
        t_boost;
        t_irq;
        final_report;
    end

    // the whole run takes well under a thousand cycles, so this only trips on a hang
    initial begin
        #(8 * 5000);
        n_errors++;
        final_report;
    end
endmodule // charger_status_and_mode_regs_test
